/* eewp_assertions.sv */
`timescale 1ns/100ps
module eewp_assertions (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Two-wire link
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_m_oe,
    input wire logic sda_d_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_DEV_CHG_SCL_LOW: assert property ($changed(sda_d_oe) |-> !scl && !$past(scl))
        else $error("device moved sda near a high scl");
    // Leaves setup margin before the next rising clock
    AST_DEV_SETUP: assert property ($changed(sda_d_oe) |=> !scl [*4])
        else $error("device moved sda too close to scl rise");
    AST_ACK_HELD: assert property ($rose(scl) && sda_d_oe |-> sda_d_oe [*8])
        else $error("device low drive dropped during high scl");
    AST_START_RELEASED: assert property (scl && $fell(sda) |-> !sda_d_oe [*8])
        else $error("device drives sda while taking a start");
    AST_STOP_RELEASED: assert property (scl && $rose(sda) |-> !sda_d_oe [*8])
        else $error("device drives sda after a stop");
    AST_SCL_LOW_SPAN: assert property ($fell(scl) |=> !scl [*8])
        else $error("scl low phase too short");
    AST_SCL_HIGH_SPAN: assert property ($rose(scl) |=> scl [*8])
        else $error("scl high phase too short");
    AST_MST_SDA_SETTLED: assert property ($rose(scl) |-> $stable(sda_m_oe) [*4])
        else $error("controller moved sda at scl rise");

    COV_ACK: cover property ($rose(scl) && sda_d_oe);
    COV_START: cover property (scl && $fell(sda));
    COV_STOP: cover property (scl && $rose(sda));
endmodule : eewp_assertions

/* eewp_ctrl.sv */
`timescale 1ns/100ps
`include "eewp_map.svh"
module eewp_ctrl
    import eewp_pkg::*;
#(
    parameter int QTR_CYC = `EEWP_SCL_QTR_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    // Two-wire link
    eewp_if.ctrl             bus
);
    localparam logic [15:0] TICK_LAST = 16'(QTR_CYC - 1);

    eewp_ctl_type q;
    eewp_ctl_type d;
    logic         mapped;
    logic         tk;
    logic         sda_in;

    always_comb begin
        d       = q;
        d.sda_s = {q.sda_s[0], bus.sda};
        sda_in  = q.sda_s[1];
        mapped  = paddr == `EEWP_OFF_CMD || paddr == `EEWP_OFF_DATA || paddr == `EEWP_OFF_STAT;
        tk      = q.tick == TICK_LAST;

        if (psel && !penable) begin
            case (paddr)
                `EEWP_OFF_DATA: d.prdata = {24'h000000, q.rx};
                `EEWP_OFF_STAT: d.prdata = {30'h00000000, q.nack, q.st != C_IDLE};
                default:        d.prdata = 32'h00000000;
            endcase
        end

        if (q.st != C_IDLE) begin
            d.tick = tk ? 16'h0000 : q.tick + 16'h0001;
            if (tk) begin
                d.ph = q.ph + 2'h1;
            end
        end

        case (q.st)
            C_IDLE: begin
                // Commands while a symbol is in flight are dropped
                if (psel && penable && pwrite && paddr == `EEWP_OFF_CMD) begin
                    d.tick = 16'h0000;
                    d.ph   = 2'h0;
                    d.bitn = 4'h0;
                    if (pwdata[`EEWP_CMD_START]) begin
                        d.st = C_START;
                    end else if (pwdata[`EEWP_CMD_WR]) begin
                        d.st = C_BIT;
                        d.rd = 1'b0;
                    end else if (pwdata[`EEWP_CMD_RD]) begin
                        d.st     = C_BIT;
                        d.rd     = 1'b1;
                        d.ackbit = pwdata[`EEWP_CMD_ACK];
                    end else if (pwdata[`EEWP_CMD_STOP]) begin
                        d.st = C_STOP;
                    end
                end
                if (psel && penable && pwrite && paddr == `EEWP_OFF_DATA) begin
                    d.sh = pwdata[7:0];
                end
            end
            C_START: begin
                // Software issues this from idle or after a byte (repeated start)
                if (tk) begin
                    case (q.ph)
                        2'h0: d.sda_low = 1'b0;
                        2'h1: d.scl     = 1'b1;
                        2'h2: d.sda_low = 1'b1;
                        default: begin
                            d.scl = 1'b0;
                            d.st  = C_IDLE;
                        end
                    endcase
                end
            end
            C_BIT: begin
                if (tk) begin
                    case (q.ph)
                        2'h0: begin
                            if (q.bitn == 4'h8) begin
                                d.sda_low = q.rd & q.ackbit;
                            end else begin
                                d.sda_low = ~q.rd & ~q.sh[7];
                            end
                        end
                        2'h1: d.scl = 1'b1;
                        2'h2: begin
                            if (q.bitn == 4'h8) begin
                                if (!q.rd) begin
                                    d.nack = sda_in;
                                end
                            end else begin
                                d.sh = {q.sh[6:0], sda_in};
                            end
                        end
                        default: begin
                            d.scl = 1'b0;
                            if (q.bitn == 4'h8) begin
                                d.st = C_IDLE;
                                if (q.rd) begin
                                    d.rx = q.sh;
                                end
                            end else begin
                                d.bitn = q.bitn + 4'h1;
                            end
                        end
                    endcase
                end
            end
            C_STOP: begin
                if (tk) begin
                    case (q.ph)
                        2'h0: d.sda_low = 1'b1;
                        2'h1: d.scl     = 1'b1;
                        2'h2: d.sda_low = 1'b0;
                        default: d.st   = C_IDLE;
                    endcase
                end
            end
            default: d.st = C_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q       <= '0;
            q.sda_s <= 2'h3;
            q.st    <= C_IDLE;
            q.scl   <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata        = q.prdata;
    assign pready        = 1'b1;
    assign pslverr       = psel & penable & ~mapped;
    assign bus.scl       = q.scl;
    assign bus.sda_m_out = 1'b0;
    assign bus.sda_m_oe  = q.sda_low;
endmodule : eewp_ctrl

/* eewp_dev.sv */
// Added by the designer: the address map.
`timescale 1ns/100ps
`include "eewp_map.svh"
module eewp_dev
    import eewp_pkg::*;
#(
    parameter logic [3:0] DEV_CODE  = 4'h5,          // Arbitrary device-type code
    parameter int         WRITE_CYC = `EEWP_TWC_CYC
) (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // Two-wire link
    eewp_if.device                           bus,
    // Straps
    input  wire logic [2:0]                  chip_select_inputs,
    input  wire logic                        wp,
    // Array write port
    output      logic                        mem_we,
    output      logic [`EEWP_ADDR_BITS-1:0]  mem_addr,
    output      logic [7:0]                  mem_wdata,
    // Array read port
    output      logic [`EEWP_ADDR_BITS-1:0]  rd_addr,
    input  wire logic [7:0]                  rd_data,
    // Status
    output      logic                        busy
);
    localparam logic [20:0] WCYC_LAST = 21'(WRITE_CYC - 1);

    eewp_dev_type q;
    eewp_dev_type d;
    logic         rise;
    logic         fall;
    logic         start_c;
    logic         stop_c;

    always_comb begin
        d        = q;
        d.mem_we = 1'b0;
        d.scl_s  = {q.scl_s[1:0], bus.scl};
        d.sda_s  = {q.sda_s[1:0], bus.sda};
        d.wp_s   = {q.wp_s[0], wp};
        rise     = q.scl_s[1] & ~q.scl_s[2];
        fall     = ~q.scl_s[1] & q.scl_s[2];
        start_c  = q.scl_s[1] & q.scl_s[2] & q.sda_s[2] & ~q.sda_s[1];
        stop_c   = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[2] & q.sda_s[1];

        // Self-timed cycle: buffered bytes go out first, then the rest of the time elapses
        if (q.busy) begin
            if (q.wcnt < 21'(`EEWP_PAGE_BYTES) && q.mask[q.wcnt[4:0]]) begin
                d.mem_we    = 1'b1;
                d.mem_addr  = {q.ptr[`EEWP_ADDR_BITS-1:`EEWP_PAGE_BITS], q.wcnt[4:0]};
                d.mem_wdata = q.pbuf[q.wcnt[4:0]];
            end
            d.wcnt = q.wcnt + 21'h000001;
            if (q.wcnt == WCYC_LAST) begin
                d.busy = 1'b0;
                d.mask = '0;
            end
        end

        if (start_c) begin
            d.st     = D_RX;
            d.cnt    = 4'h0;
            d.idx    = 2'h0;
            d.sda_oe = 1'b0;
        end else if (stop_c) begin
            d.st     = D_IDLE;
            d.sda_oe = 1'b0;
            if (!q.rw && |q.mask && !q.busy) begin
                if (!q.wp_s[1]) begin
                    d.busy = 1'b1;
                    d.wcnt = 21'h000000;
                end else begin
                    d.mask = '0;
                end
            end
        end else begin
            case (q.st)
                D_RX: begin
                    if (rise) begin
                        d.sh  = {q.sh[6:0], q.sda_s[1]};
                        d.cnt = q.cnt + 4'h1;
                    end else if (fall && q.cnt == 4'h8) begin
                        d.cnt = 4'h0;
                        case (q.idx)
                            2'h0: begin
                                // Busy check silences polling until the cycle ends
                                if (q.sh[7:4] == DEV_CODE && q.sh[3:1] == chip_select_inputs
                                    && !q.busy) begin
                                    d.rw     = q.sh[0];
                                    d.st     = D_ACK;
                                    d.sda_oe = 1'b1;
                                    if (!q.sh[0]) begin
                                        d.mask = '0;
                                    end
                                end else begin
                                    d.st = D_IGN;
                                end
                            end
                            2'h1: begin
                                d.ptr[`EEWP_ADDR_BITS-1:8] = q.sh[`EEWP_ADDR_BITS-9:0];
                                d.st     = D_ACK;
                                d.sda_oe = 1'b1;
                            end
                            2'h2: begin
                                d.ptr[7:0] = q.sh;
                                d.st       = D_ACK;
                                d.sda_oe   = 1'b1;
                            end
                            default: begin
                                d.pbuf[q.ptr[4:0]] = q.sh;
                                d.mask[q.ptr[4:0]] = 1'b1;
                                d.ptr[4:0] = q.ptr[4:0] + 5'h01;
                                d.st       = D_ACK;
                                d.sda_oe   = 1'b1;
                            end
                        endcase
                    end
                end
                D_ACK: begin
                    // Held from the fall before the ninth pulse to the fall after it
                    if (fall) begin
                        d.idx = (q.idx == 2'h3) ? 2'h3 : q.idx + 2'h1;
                        if (q.rw) begin
                            d.st     = D_TX;
                            d.sh     = rd_data;
                            d.sda_oe = ~rd_data[7];
                            d.cnt    = 4'h0;
                        end else begin
                            d.st     = D_RX;
                            d.sda_oe = 1'b0;
                        end
                    end
                end
                D_TX: begin
                    if (fall) begin
                        if (q.cnt == 4'h7) begin
                            d.st     = D_TXACK;
                            d.sda_oe = 1'b0;
                            d.ptr    = q.ptr + 13'h0001;
                        end else begin
                            d.sh     = {q.sh[6:0], 1'b0};
                            d.sda_oe = ~q.sh[6];
                            d.cnt    = q.cnt + 4'h1;
                        end
                    end
                end
                D_TXACK: begin
                    if (rise) begin
                        d.mack = ~q.sda_s[1];
                    end else if (fall) begin
                        if (q.mack) begin
                            d.st     = D_TX;
                            d.sh     = rd_data;
                            d.sda_oe = ~rd_data[7];
                            d.cnt    = 4'h0;
                        end else begin
                            d.st = D_IGN;
                        end
                    end
                end
                D_IDLE, D_IGN: begin
                    d.sda_oe = 1'b0;
                end
                default: begin
                    d.st     = D_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q       <= '0;
            q.scl_s <= 3'h7;
            q.sda_s <= 3'h7;
            q.st    <= D_IDLE;
        end else begin
            q <= d;
        end
    end

    assign bus.sda_d_out = 1'b0;
    assign bus.sda_d_oe  = q.sda_oe;
    assign mem_we        = q.mem_we;
    assign mem_addr      = q.mem_addr;
    assign mem_wdata     = q.mem_wdata;
    assign rd_addr       = q.ptr;
    assign busy          = q.busy;
endmodule : eewp_dev

/* eewp_if.sv */
`timescale 1ns/100ps
interface eewp_if;
    logic scl;
    logic sda_m_out;
    logic sda_m_oe;
    logic sda_d_out;
    logic sda_d_oe;
    logic sda;

    // Open-drain wire with pull-up
    assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_d_oe & ~sda_d_out));

    modport device (input scl, input sda, output sda_d_out, output sda_d_oe);
    modport ctrl   (output scl, output sda_m_out, output sda_m_oe, input sda);
endinterface : eewp_if

/* eewp_map.svh */
`ifndef EEWP_MAP_SVH
`define EEWP_MAP_SVH

`define EEWP_ADDR_BITS   13
`define EEWP_PAGE_BITS   5
`define EEWP_PAGE_BYTES  32
`define EEWP_CLK_NS      4
`define EEWP_TWC_NS      5000000
`define EEWP_TWC_CYC     (`EEWP_TWC_NS / `EEWP_CLK_NS)
`define EEWP_SCL_QTR_NS  625
`define EEWP_SCL_QTR_CYC ((`EEWP_SCL_QTR_NS + `EEWP_CLK_NS - 1) / `EEWP_CLK_NS)

`define EEWP_OFF_CMD     8'h00
`define EEWP_OFF_DATA    8'h04
`define EEWP_OFF_STAT    8'h08
`define EEWP_CMD_START   0
`define EEWP_CMD_STOP    1
`define EEWP_CMD_WR      2
`define EEWP_CMD_RD      3
`define EEWP_CMD_ACK     4
`define EEWP_STAT_BUSY   0
`define EEWP_STAT_NACK   1
`endif

/* eewp_pkg.sv */
`include "eewp_map.svh"
package eewp_pkg;
    typedef enum logic [5:0] {
        D_IDLE  = 6'h01,
        D_RX    = 6'h02,
        D_ACK   = 6'h04,
        D_TX    = 6'h08,
        D_TXACK = 6'h10,
        D_IGN   = 6'h20
    } eewp_dst_type;

    typedef enum logic [3:0] {
        C_IDLE  = 4'h1,
        C_START = 4'h2,
        C_BIT   = 4'h4,
        C_STOP  = 4'h8
    } eewp_cst_type;

    typedef struct packed {
        logic [2:0]                         scl_s;
        logic [2:0]                         sda_s;
        logic [1:0]                         wp_s;
        eewp_dst_type                       st;
        logic [3:0]                         cnt;
        logic [1:0]                         idx;
        logic                               rw;
        logic [7:0]                         sh;
        logic [`EEWP_ADDR_BITS-1:0]         ptr;
        logic [`EEWP_PAGE_BYTES-1:0][7:0]   pbuf;
        logic [`EEWP_PAGE_BYTES-1:0]        mask;
        logic                               mack;
        logic                               sda_oe;
        logic                               busy;
        logic [20:0]                        wcnt;
        logic                               mem_we;
        logic [`EEWP_ADDR_BITS-1:0]         mem_addr;
        logic [7:0]                         mem_wdata;
    } eewp_dev_type;

    typedef struct packed {
        logic [1:0]   sda_s;
        eewp_cst_type st;
        logic [15:0]  tick;
        logic [1:0]   ph;
        logic [3:0]   bitn;
        logic         rd;
        logic         ackbit;
        logic [7:0]   sh;
        logic [7:0]   rx;
        logic         nack;
        logic         scl;
        logic         sda_low;
        logic [31:0]  prdata;
    } eewp_ctl_type;
endpackage : eewp_pkg

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import eewp_pkg::*;
    localparam logic [3:0] DCODE = 4'h5; // Arbitrary device-type code
    localparam logic [2:0] CS    = 3'h5;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        wp;
    logic        pready;
    logic        pslverr;
    logic        mem_we;
    logic        busy;
    logic        rs;
    logic [7:0]  paddr;
    logic [7:0]  mem_wdata;
    logic [7:0]  rd_data;
    logic [12:0] mem_addr;
    logic [12:0] rd_addr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rv;
    int          err_total;
    int          total_checks;
    bit   [7:0]  mem [0:8191];

    always #2 pclk = ~pclk;

    eewp_if i_eewp_if ();
    eewp_ctrl #(.QTR_CYC(8)) i_eewp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus(i_eewp_if));
    // Write cycle long enough that a poll can land inside it
    eewp_dev #(.DEV_CODE(DCODE), .WRITE_CYC(2000)) i_eewp_dev (.pclk(pclk), .presetn(presetn),
        .bus(i_eewp_if), .chip_select_inputs(CS), .wp(wp), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .rd_addr(rd_addr), .rd_data(rd_data),
        .busy(busy));
    eewp_assertions i_eewp_assertions (.pclk(pclk), .presetn(presetn), .scl(i_eewp_if.scl),
        .sda(i_eewp_if.sda), .sda_m_oe(i_eewp_if.sda_m_oe), .sda_d_oe(i_eewp_if.sda_d_oe));

    always @(posedge pclk) if (mem_we) mem[mem_addr] <= mem_wdata;
    assign rd_data = mem[rd_addr];

    task check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            err_total++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
        end
    endtask : check

    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // Idle cycle after each transfer keeps two calls from driving one edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog bounds this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv = prdata;
        rs = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task cmd(input logic [7:0] c);
        int n;
        apb(1'b1, 8'h00, {24'h0, c});
        n = 0;
        do begin
            apb(1'b0, 8'h08, 32'h0);
            n++;
        end while (rv[0] !== 1'b0 && n < 400);
        check(rv[0], 1'b0);
    endtask : cmd

    task send(input logic [7:0] b, input logic nk);
        apb(1'b1, 8'h04, {24'h0, b});
        cmd(8'h04);
        check(rv[1], nk);
    endtask : send

    task wbusy(input logic v);
        int n;
        n = 0;
        while (busy !== v && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        check(busy, v);
    endtask : wbusy

    function automatic logic [7:0] ctl(input logic [2:0] c, input logic r);
        return {DCODE, c, r};
    endfunction : ctl

    task t_byte;
        cmd(8'h01);
        send(ctl(CS, 1'b0), 1'b0);
        send(8'hE1, 1'b0);
        send(8'h23, 1'b0);
        send(8'h5A, 1'b0);
        cmd(8'h02);
        check(busy, 1'b1);
        check(rd_addr, 13'h0124);
        cmd(8'h01);
        send(ctl(CS, 1'b0), 1'b1);
        cmd(8'h02);
        wbusy(1'b0);
        check(mem[13'h0123], 8'h5A);
        cmd(8'h01);
        send(ctl(CS, 1'b0), 1'b0);
        cmd(8'h02);
    endtask : t_byte

    task t_page;
        logic [7:0] pexp [32];
        cmd(8'h01);
        send(ctl(CS, 1'b0), 1'b0);
        send(8'h00, 1'b0);
        send(8'h5E, 1'b0);
        for (int i = 0; i < 34; i++) begin
            send(8'hA0 + i[7:0], 1'b0);
            pexp[(30 + i) % 32] = 8'hA0 + i[7:0];
        end
        check(mem[13'h005E], 8'h00);
        cmd(8'h02);
        wbusy(1'b1);
        wbusy(1'b0);
        for (int k = 0; k < 32; k++) check(mem[13'h0040 + k], pexp[k]);
    endtask : t_page

    task t_select;
        cmd(8'h01);
        send(ctl(~CS, 1'b0), 1'b1);
        send(8'h00, 1'b1);
        cmd(8'h01);
        send({~DCODE, CS, 1'b0}, 1'b1);
        cmd(8'h02);
    endtask : t_select

    task t_protect;
        wp <= 1'b1;
        cmd(8'h01);
        send(ctl(CS, 1'b0), 1'b0);
        send(8'h02, 1'b0);
        send(8'h00, 1'b0);
        send(8'h77, 1'b0);
        cmd(8'h02);
        check(busy, 1'b0);
        cmd(8'h01);
        send(ctl(CS, 1'b0), 1'b0);
        send(8'h01, 1'b0);
        send(8'h23, 1'b0);
        cmd(8'h01);
        send(ctl(CS, 1'b1), 1'b0);
        cmd(8'h08);
        apb(1'b0, 8'h04, 32'h0);
        check(rv[7:0], 8'h5A);
        check(rd_addr, 13'h0124);
        cmd(8'h02);
        check(i_eewp_if.sda, 1'b1);
        check(mem[13'h0200], 8'h00);
        wp <= 1'b0;
        cmd(8'h01);
        send(ctl(CS, 1'b0), 1'b0);
        send(8'h02, 1'b0);
        send(8'h00, 1'b0);
        send(8'h33, 1'b0);
        cmd(8'h02);
        wp <= 1'b1;
        wbusy(1'b0);
        check(mem[13'h0200], 8'h33);
        wp <= 1'b0;
    endtask : t_protect

    initial begin
        pclk         = 1'b0;
        presetn      = 1'b0;
        {psel, penable, pwrite, wp} = 4'h0;
        paddr        = 8'h00;
        pwdata       = 32'h0;
        err_total    = 0;
        total_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(i_eewp_if.sda, 1'b1);
        check(i_eewp_if.scl, 1'b1);
        t_byte();
        t_page();
        t_select();
        t_protect();
        apb(1'b0, 8'h0C, 32'h0);
        check(rs, 1'b1);
        check(rv, 32'h0);
        print_verdict();
    end

    // The run needs about 24k cycles; this limit leaves wide margin
    initial begin
        #400000;
        err_total++;
        print_verdict();
    end
endmodule : tb_top
